//--- fsxo_core.sv
// Execution unit for far skip, table read and exclusive-OR operations
`timescale 1ns/1ps
module fsxo_core (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Operation from the fetch sequencer
	input wire logic op_valid_in,
	input wire logic [3:0] op_code_in,
	input wire logic [2:0] bit_sel_in,
	// Data memory operand
	input wire logic [7:0] mem_rdata_in,
	// Program memory read data, valid in the same cycle as the request
	input wire logic [15:0] prog_rdata_in,
	// Pointer writes from software path
	input wire logic ptr_hi_we_in,
	input wire logic ptr_lo_we_in,
	input wire logic [7:0] ptr_wdata_in,
	// Sequencer handshakes
	output logic op_ready_out,
	output logic skip_out,
	output logic busy_out,
	// Data memory write
	output logic mem_we_out,
	output logic [7:0] mem_wdata_out,
	// Program memory read
	output logic prog_re_out,
	output logic [15:0] prog_addr_out,
	// Architectural state
	output logic [7:0] acc_out,
	output logic zero_flag_out,
	output logic zero_we_out,
	output logic [7:0] ptr_hi_out,
	output logic [7:0] ptr_lo_out,
	output logic [7:0] tbl_high_out
);
	fsxo_pkg::fsxo_state_t state_r, state_nxt;
	logic [7:0] acc_r, acc_nxt, ptr_hi_r, ptr_lo_r, ptr_lo_nxt, tbh_r, tbh_nxt;
	logic [7:0] mem_wdata_r, mem_wdata_nxt;
	logic mem_we_r, mem_we_nxt, zf_r, zf_nxt, zwe_r, zwe_nxt, skip_r, skip_nxt;
	logic prog_re_r, prog_re_nxt;

	//////////////////////////////////////////////////////////////////////////
	// Decode
	wire logic go = op_valid_in && state_r == fsxo_pkg::FSXO_IDLE;
	wire logic is_skip = op_code_in == fsxo_pkg::OP_SKIP_NULL;
	wire logic is_copy = op_code_in == fsxo_pkg::OP_COPY_SKIP;
	wire logic is_bit = op_code_in == fsxo_pkg::OP_BIT_SKIP;
	wire logic is_trd = op_code_in >= fsxo_pkg::OP_TRD_PAGE && op_code_in <= fsxo_pkg::OP_TRD_INC_LAST;
	wire logic trd_inc = op_code_in == fsxo_pkg::OP_TRD_INC_PAGE
		|| op_code_in == fsxo_pkg::OP_TRD_INC_LAST;
	wire logic trd_last = op_code_in == fsxo_pkg::OP_TRD_LAST
		|| op_code_in == fsxo_pkg::OP_TRD_INC_LAST;
	wire logic is_xa = op_code_in == fsxo_pkg::OP_XOR_ACC;
	wire logic is_xm = op_code_in == fsxo_pkg::OP_XOR_MEM;
	wire logic byte_null = mem_rdata_in == 8'h00;
	wire logic bit_null = !mem_rdata_in[bit_sel_in];
	wire logic [7:0] xor_val = acc_r ^ mem_rdata_in;
	wire logic [7:0] ptr_lo_used = trd_inc ? 8'(ptr_lo_r + 8'h01) : ptr_lo_r;
	wire logic take_skip = go && (((is_skip || is_copy) && byte_null) || (is_bit && bit_null));
	wire logic [15:0] paddr;
	logic last_r;

	// Address former, lower pointer already incremented when asked
	fsxo_tbl_addr u_addr (
		.ptr_hi_in(ptr_hi_r),
		.ptr_lo_in(ptr_lo_used),
		.last_page_in(trd_last),
		.paddr_out(paddr)
	);

	//////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		state_nxt = state_r;
		acc_nxt = acc_r;
		ptr_lo_nxt = ptr_lo_r;
		tbh_nxt = tbh_r;
		mem_we_nxt = 1'b0;
		mem_wdata_nxt = mem_wdata_r;
		zf_nxt = zf_r;
		zwe_nxt = 1'b0;
		skip_nxt = 1'b0;
		prog_re_nxt = 1'b0;
		case (state_r)
			fsxo_pkg::FSXO_IDLE: begin
				if (go && is_skip) begin
					mem_we_nxt = 1'b1; // Rewrite unchanged
					mem_wdata_nxt = mem_rdata_in;
				end
				if (go && is_copy)
					acc_nxt = mem_rdata_in;
				if (take_skip) begin
					skip_nxt = 1'b1; // Flags untouched
					state_nxt = fsxo_pkg::FSXO_DUMMY;
				end
				if (go && is_trd) begin
					ptr_lo_nxt = ptr_lo_used;
					prog_re_nxt = 1'b1;
					state_nxt = fsxo_pkg::FSXO_TRD;
				end
				if (go && is_xa) begin
					acc_nxt = xor_val;
					zf_nxt = xor_val == 8'h00;
					zwe_nxt = 1'b1;
				end
				if (go && is_xm) begin
					mem_we_nxt = 1'b1;
					mem_wdata_nxt = xor_val;
					zf_nxt = xor_val == 8'h00;
					zwe_nxt = 1'b1;
				end
			end
			fsxo_pkg::FSXO_TRD: begin
				// Split the word, no flag change
				mem_we_nxt = 1'b1;
				mem_wdata_nxt = prog_rdata_in[7:0];
				tbh_nxt = prog_rdata_in[15:8];
				state_nxt = fsxo_pkg::FSXO_IDLE;
			end
			fsxo_pkg::FSXO_DUMMY: state_nxt = fsxo_pkg::FSXO_IDLE;
			default: state_nxt = fsxo_pkg::FSXO_IDLE;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// State registers
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_r <= fsxo_pkg::FSXO_IDLE;
			acc_r <= fsxo_pkg::ACC_RST;
			ptr_hi_r <= fsxo_pkg::PTR_RST;
			ptr_lo_r <= fsxo_pkg::PTR_RST;
			tbh_r <= fsxo_pkg::TBH_RST;
			mem_we_r <= 1'b0;
			mem_wdata_r <= 8'h00;
			zf_r <= 1'b0;
			zwe_r <= 1'b0;
			skip_r <= 1'b0;
			prog_re_r <= 1'b0;
			prog_addr_out <= 16'h0000;
			last_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			acc_r <= acc_nxt;
			ptr_hi_r <= ptr_hi_we_in ? ptr_wdata_in : ptr_hi_r;
			ptr_lo_r <= (ptr_lo_we_in && !(go && is_trd)) ? ptr_wdata_in : ptr_lo_nxt;
			tbh_r <= tbh_nxt;
			mem_we_r <= mem_we_nxt;
			mem_wdata_r <= mem_wdata_nxt;
			zf_r <= zf_nxt;
			zwe_r <= zwe_nxt;
			skip_r <= skip_nxt;
			prog_re_r <= prog_re_nxt;
			if (go && is_trd)
				prog_addr_out <= paddr;
			if (go)
				last_r <= trd_last;
		end
	end

	// Outputs
	assign op_ready_out = state_r == fsxo_pkg::FSXO_IDLE;
	assign busy_out = state_r != fsxo_pkg::FSXO_IDLE;
	assign skip_out = skip_r;
	assign mem_we_out = mem_we_r;
	assign mem_wdata_out = mem_wdata_r;
	assign prog_re_out = prog_re_r;
	assign acc_out = acc_r;
	assign zero_flag_out = zf_r;
	assign zero_we_out = zwe_r;
	assign ptr_hi_out = ptr_hi_r;
	assign ptr_lo_out = ptr_lo_r;
	assign tbl_high_out = tbh_r;

	//////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_skip_taken;
		go && take_skip;
	endsequence
	sequence s_dummy_then_idle;
		skip_out && busy_out ##1 op_ready_out;
	endsequence

	AST_COPY_LOAD: assert property (@(posedge clk_in) disable iff (rst_in)
		go && is_copy |=> acc_out == $past(mem_rdata_in))
		else $error("copy skip did not load accumulator");
	AST_SKIP_THREE: assert property (@(posedge clk_in) disable iff (rst_in)
		s_skip_taken |=> s_dummy_then_idle)
		else $error("taken skip did not last three cycles");
	AST_BIT_SKIP: assert property (@(posedge clk_in) disable iff (rst_in)
		go && is_bit |=> skip_out == !$past(mem_rdata_in[bit_sel_in]))
		else $error("bit skip decision wrong");
	AST_SKIP_NO_FLAG: assert property (@(posedge clk_in) disable iff (rst_in)
		go && (is_skip || is_copy || is_bit) |=> !zero_we_out && $stable(zero_flag_out))
		else $error("skip changed a flag");
	AST_TRD_SPLIT: assert property (@(posedge clk_in) disable iff (rst_in)
		go && is_trd |=> ##1 mem_we_out && mem_wdata_out == $past(prog_rdata_in[7:0])
		&& tbl_high_out == $past(prog_rdata_in[15:8]))
		else $error("table word not split");
	AST_TRD_LAST: assert property (@(posedge clk_in) disable iff (rst_in)
		prog_re_out && last_r |-> prog_addr_out[15:8] == fsxo_pkg::LAST_PAGE
		&& prog_addr_out[7:0] == ptr_lo_out)
		else $error("last page address wrong");
	AST_TRD_INC: assert property (@(posedge clk_in) disable iff (rst_in)
		go && trd_inc && !ptr_lo_we_in |=> ptr_lo_out == 8'($past(ptr_lo_out) + 8'h01))
		else $error("pointer not pre-incremented");
	AST_TRD_NO_FLAG: assert property (@(posedge clk_in) disable iff (rst_in)
		go && is_trd |=> !zero_we_out [*2])
		else $error("table read touched flag");
	AST_XOR_ACC: assert property (@(posedge clk_in) disable iff (rst_in)
		go && is_xa |=> acc_out == $past(xor_val) && zero_we_out
		&& zero_flag_out == (acc_out == 8'h00) && !mem_we_out)
		else $error("xor to acc wrong");
	AST_XOR_MEM: assert property (@(posedge clk_in) disable iff (rst_in)
		go && is_xm |=> mem_we_out && mem_wdata_out == $past(xor_val)
		&& zero_flag_out == (mem_wdata_out == 8'h00) && $stable(acc_out))
		else $error("xor to memory wrong");
	AST_BYTE_SKIP: assert property (@(posedge clk_in) disable iff (rst_in)
		go && is_skip |=> mem_we_out && mem_wdata_out == $past(mem_rdata_in)
		&& skip_out == ($past(mem_rdata_in) == 8'h00))
		else $error("byte skip wrong");
endmodule

//--- fsxo_pkg.sv
// Shared constants and types for the far skip, table read and exclusive-OR unit
package fsxo_pkg;
	localparam int DATA_W = 8;
	localparam int PROG_W = 16;
	localparam int PADDR_W = 16;
	localparam int BIT_SEL_W = 3;
	localparam logic [7:0] LAST_PAGE = 8'hff;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [7:0] TBH_RST = 8'h00;
	localparam int SKIP_CYCLES = 3;
	localparam int OP_W = 4;
	// Operation codes presented by the fetch sequencer
	localparam logic [3:0] OP_NONE = 4'h0;
	localparam logic [3:0] OP_SKIP_NULL = 4'h1;
	localparam logic [3:0] OP_COPY_SKIP = 4'h2;
	localparam logic [3:0] OP_BIT_SKIP = 4'h3;
	localparam logic [3:0] OP_TRD_PAGE = 4'h4;
	localparam logic [3:0] OP_TRD_LAST = 4'h5;
	localparam logic [3:0] OP_TRD_INC_PAGE = 4'h6;
	localparam logic [3:0] OP_TRD_INC_LAST = 4'h7;
	localparam logic [3:0] OP_XOR_ACC = 4'h8;
	localparam logic [3:0] OP_XOR_MEM = 4'h9;
	typedef enum logic [1:0] {FSXO_IDLE, FSXO_TRD, FSXO_DUMMY} fsxo_state_t;
endpackage

//--- fsxo_tbl_addr.sv
// Program address former for the table reads
`timescale 1ns/1ps
module fsxo_tbl_addr (
	// Pointer values
	input wire logic [7:0] ptr_hi_in,
	input wire logic [7:0] ptr_lo_in,
	// Page select
	input wire logic last_page_in,
	// Formed address
	output logic [15:0] paddr_out
);
	// Last page ignores the upper pointer
	assign paddr_out = last_page_in ? {fsxo_pkg::LAST_PAGE, ptr_lo_in} : {ptr_hi_in, ptr_lo_in};
endmodule

//--- fsxo_prog_model.sv
// Program memory stand-in answering table fetches
`timescale 1ns/1ps
module fsxo_prog_model (
	// Fetch request
	input wire logic prog_re_in,
	input wire logic [15:0] prog_addr_in,
	// Program word
	output logic [15:0] prog_rdata_out
);
	// Scrambled address as word; inverse shown when not fetched, so stale data never matches
	logic [15:0] word;
	assign word = prog_addr_in ^ 16'h3c5a;
	assign prog_rdata_out = prog_re_in ? word : ~word;
endmodule

//--- fsxo_core_tb.sv
// Self-checking bench for the far skip, table read and exclusive-OR unit
`timescale 1ns/1ps
module fsxo_core_tb;
	logic clk_in, rst_in, op_valid, ptr_hi_we, ptr_lo_we, re, skip, busy, ready, mwe, z, zwe;
	logic [3:0] code;
	logic [2:0] bsel;
	logic [7:0] mrd, pwd, mwd, acc, phi, plo, tbh;
	logic [15:0] prd, paddr;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	// Unit and program memory
	fsxo_core dut (.clk_in(clk_in), .rst_in(rst_in), .op_valid_in(op_valid), .op_code_in(code),
		.bit_sel_in(bsel), .mem_rdata_in(mrd), .prog_rdata_in(prd), .ptr_hi_we_in(ptr_hi_we),
		.ptr_lo_we_in(ptr_lo_we), .ptr_wdata_in(pwd), .op_ready_out(ready), .skip_out(skip),
		.busy_out(busy), .mem_we_out(mwe), .mem_wdata_out(mwd), .prog_re_out(re),
		.prog_addr_out(paddr), .acc_out(acc), .zero_flag_out(z), .zero_we_out(zwe),
		.ptr_hi_out(phi), .ptr_lo_out(plo), .tbl_high_out(tbh));
	fsxo_prog_model prog (.prog_re_in(re), .prog_addr_in(paddr), .prog_rdata_out(prd));
	////////////////////////////////////////////////////////////////////////////////
	// Clock, 5 ns period
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	// Hang guard
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("Compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One operation; returns in the cycle after it is taken
	task automatic issue(input logic [3:0] c, input logic [7:0] d, input logic [2:0] b);
		@(posedge clk_in);
		op_valid <= 1'b1;
		code <= c;
		mrd <= d;
		bsel <= b;
		@(posedge clk_in);
		op_valid <= 1'b0;
		mrd <= ~d;
		#1;
	endtask
	task automatic set_ptr(input logic hi, input logic [7:0] v);
		@(posedge clk_in);
		ptr_hi_we <= hi;
		ptr_lo_we <= !hi;
		pwd <= v;
		@(posedge clk_in);
		ptr_hi_we <= 1'b0;
		ptr_lo_we <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_xor();
		issue(fsxo_pkg::OP_XOR_ACC, 8'h3c, 3'h0);
		check(16'({acc, z, zwe, mwe}), 16'({8'h3c, 3'b010}));
		issue(fsxo_pkg::OP_XOR_ACC, 8'h3c, 3'h0);
		check(16'({acc, z, zwe}), 16'({8'h00, 2'b11}));
		issue(fsxo_pkg::OP_XOR_ACC, 8'h5a, 3'h0);
		issue(fsxo_pkg::OP_XOR_MEM, 8'h5a, 3'h0);
		check(16'({mwd, mwe, z, zwe}), 16'({8'h00, 3'b111}));
		check(16'(acc), 16'h005a);
		issue(fsxo_pkg::OP_XOR_MEM, 8'h18, 3'h0);
		check(16'({mwd, mwe, z, zwe}), 16'({8'h42, 3'b101}));
	endtask
	task automatic test_skip();
		issue(fsxo_pkg::OP_SKIP_NULL, 8'h00, 3'h0);
		check(16'({skip, busy, mwe, mwd, zwe, z}), 16'({3'b111, 8'h00, 2'b00}));
		@(posedge clk_in);
		#1;
		check(16'({ready, skip}), 16'h0002);
		issue(fsxo_pkg::OP_SKIP_NULL, 8'h81, 3'h0);
		check(16'({skip, busy, mwe, mwd}), 16'({3'b001, 8'h81}));
		issue(fsxo_pkg::OP_COPY_SKIP, 8'h00, 3'h0);
		check(16'({skip, busy, acc, zwe}), 16'({2'b11, 8'h00, 1'b0}));
		issue(fsxo_pkg::OP_COPY_SKIP, 8'h7e, 3'h0);
		check(16'({skip, acc, mwe}), 16'({1'b0, 8'h7e, 1'b0}));
		for (int i = 0; i < 8; i++) begin
			issue(fsxo_pkg::OP_BIT_SKIP, 8'hf7, i[2:0]);
			check(16'({skip, zwe, z}), 16'({i == 3, 2'b00}));
		end
	endtask
	// All four read kinds twice, lower pointer wrapping during the first pass
	task automatic test_table();
		logic [15:0] a;
		logic [7:0] lo;
		set_ptr(1'b1, 8'h12);
		set_ptr(1'b0, 8'hfe);
		lo = 8'hfe;
		for (int k = 0; k < 8; k++) begin
			if (k[1])
				lo = lo + 8'h01;
			a = {k[0] ? fsxo_pkg::LAST_PAGE : 8'h12, lo};
			issue(fsxo_pkg::OP_TRD_PAGE + 4'(k % 4), 8'h00, 3'h0);
			check(16'({re, busy, zwe, mwe}), 16'h000c);
			check(paddr, a);
			check(16'(plo), 16'(lo));
			@(posedge clk_in);
			#1;
			check(16'({mwe, mwd, zwe}), 16'({1'b1, a[7:0] ^ 8'h5a, 1'b0}));
			check(16'(tbh), 16'(a[15:8] ^ 8'h3c));
		end
		check(16'(phi), 16'h0012);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst_in = 1'b1;
		{op_valid, ptr_hi_we, ptr_lo_we} = 3'b000;
		{code, bsel, mrd, pwd} = 23'h0;
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		#1;
		check(16'({ready, acc, z}), 16'({1'b1, 9'h000}));
		test_xor();
		test_skip();
		test_table();
		complete_run();
	end
endmodule
